// ### lvs_pkg.sv
// Operation
// - Bit 7 of the first regulator register selects sleep (1) or normal (0) mode.
// - Bit 7 of the second regulator register selects sleep (1) or normal (0) mode.
// - Bits 5:0 of the first register hold a voltage code, codes above 111000 saturate.
// - Bits 5:0 of the second register hold a voltage code on the same saturating scale.
package lvs_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam int          CODE_W          = 6;
  localparam logic [7:0]  REG7_A_OFFSET   = 8'haf;
  localparam logic [7:0]  REG8_A_OFFSET   = 8'hb0;
  localparam logic [7:0]  REG_RESET       = 8'h00;
  // ---------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------
  localparam int          SLEEP_BIT       = 7;
  localparam int          RSVD_BIT        = 6;
  localparam int          CODE_MSB        = 5;
  localparam logic [5:0]  CODE_MAX        = 6'h38;
  localparam logic [7:0]  READ_UNMAPPED   = 8'h00;
  // Effective code steps: 0.90 V at code 2 and below, 0.05 V per step
  localparam logic [5:0]  CODE_FLOOR      = 6'h02;
endpackage

// ### lvs_reg_if.sv
`timescale 1ns/100ps
// Bundle from the register file to one regulator decoder
interface lvs_reg_if;
  logic [7:0] value;
  modport src (output value);
  modport dst (input  value);
endinterface

// ### lvs_decode.sv
`timescale 1ns/100ps
// Splits one setting register into mode and saturated voltage step
module lvs_decode
(
  input  wire logic clk_sys_i,
  input  wire logic reset_n_i,
  lvs_reg_if.dst    reg_in,
  output logic      sleep_o,
  output logic [5:0] code_o,
  output logic [5:0] step_o
);
  logic [5:0] raw_code;
  logic [5:0] next_step;

  // Field extraction
  assign raw_code = reg_in.value[lvs_pkg::CODE_MSB:0];

  // Saturate above the top code, clamp the low floor
  always_comb
  begin
    if (raw_code > lvs_pkg::CODE_MAX)
      next_step = lvs_pkg::CODE_MAX - lvs_pkg::CODE_FLOOR;
    else if (raw_code < lvs_pkg::CODE_FLOOR)
      next_step = 6'h00;
    else
      next_step = raw_code - lvs_pkg::CODE_FLOOR;
  end

  // Registered outputs
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sleep_o <= 1'b0;
      code_o  <= 6'h00;
      step_o  <= 6'h00;
    end
    else
    begin
      sleep_o <= reg_in.value[lvs_pkg::SLEEP_BIT];
      code_o  <= raw_code;
      step_o  <= next_step;
    end
  end

  property p_saturate;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (raw_code > lvs_pkg::CODE_MAX) |=> (step_o == lvs_pkg::CODE_MAX - lvs_pkg::CODE_FLOOR);
  endproperty
  a_saturate: assert property (p_saturate) else $error("step not saturated");
endmodule

// ### lvs_top.sv
`timescale 1ns/100ps
// Two A-bank regulator setting registers with mode and voltage outputs
module lvs_top
(
  input  wire logic       clk_sys_i,
  input  wire logic       reset_n_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  output logic            reg7_sleep_select_bank_a_o,
  output logic      [5:0] reg7_voltage_code_bank_a_o,
  output logic      [5:0] reg7_voltage_step_o,
  output logic            reg8_sleep_select_bank_a_o,
  output logic      [5:0] reg8_voltage_code_bank_a_o,
  output logic      [5:0] reg8_voltage_step_o
);
  logic [7:0] regulator7_bank_a_setting;
  logic [7:0] regulator8_bank_a_setting;
  logic       hit7;
  logic       hit8;
  lvs_reg_if  r7_if ();
  lvs_reg_if  r8_if ();

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  always_comb
  begin
    hit7 = 1'b0;
    hit8 = 1'b0;
    if (addr_i == lvs_pkg::REG7_A_OFFSET)
      hit7 = 1'b1;
    else if (addr_i == lvs_pkg::REG8_A_OFFSET)
      hit8 = 1'b1;
  end

  // ---------------------------------------------------------------
  // Register storage, all eight bits kept
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      regulator7_bank_a_setting <= lvs_pkg::REG_RESET;
    else if (wr_i && hit7)
      regulator7_bank_a_setting <= wdata_i;
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      regulator8_bank_a_setting <= lvs_pkg::REG_RESET;
    else if (wr_i && hit8)
      regulator8_bank_a_setting <= wdata_i;
  end

  // Read data, valid the cycle after the strobe
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rdata_o <= lvs_pkg::READ_UNMAPPED;
    else if (rd_i && hit7)
      rdata_o <= regulator7_bank_a_setting;
    else if (rd_i && hit8)
      rdata_o <= regulator8_bank_a_setting;
    else if (rd_i)
      rdata_o <= lvs_pkg::READ_UNMAPPED;
  end

  // ---------------------------------------------------------------
  // Regulator decoders
  // ---------------------------------------------------------------
  assign r7_if.value = regulator7_bank_a_setting;
  assign r8_if.value = regulator8_bank_a_setting;

  // Mode and code for the first regulator
  lvs_decode u_dec7
  (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .reg_in    (r7_if),
    .sleep_o   (reg7_sleep_select_bank_a_o),
    .code_o    (reg7_voltage_code_bank_a_o),
    .step_o    (reg7_voltage_step_o)
  );

  // Mode and code for the second regulator
  lvs_decode u_dec8
  (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .reg_in    (r8_if),
    .sleep_o   (reg8_sleep_select_bank_a_o),
    .code_o    (reg8_voltage_code_bank_a_o),
    .step_o    (reg8_voltage_step_o)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_sleep7;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (wr_i && hit7) |=> ##1
        (reg7_sleep_select_bank_a_o == $past(wdata_i[lvs_pkg::SLEEP_BIT], 2));
  endproperty
  a_sleep7: assert property (p_sleep7) else $error("sleep7 wrong");

  property p_sleep8;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (wr_i && hit8) |=> ##1
        (reg8_sleep_select_bank_a_o == $past(wdata_i[lvs_pkg::SLEEP_BIT], 2));
  endproperty
  a_sleep8: assert property (p_sleep8) else $error("sleep8 wrong");

  property p_code7;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (wr_i && hit7 && wdata_i[lvs_pkg::CODE_MSB:0] > lvs_pkg::CODE_MAX) |=> ##1
        (reg7_voltage_step_o == lvs_pkg::CODE_MAX - lvs_pkg::CODE_FLOOR);
  endproperty
  a_code7: assert property (p_code7) else $error("code7 not saturated");

  property p_code8;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (wr_i && hit8) |=> ##1
        (reg8_voltage_code_bank_a_o == $past(wdata_i[lvs_pkg::CODE_MSB:0], 2));
  endproperty
  a_code8: assert property (p_code8) else $error("code8 wrong");

  property p_read7;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (rd_i && hit7) |=> (rdata_o == $past(regulator7_bank_a_setting));
  endproperty
  a_read7: assert property (p_read7) else $error("read7 mismatch");

  property p_wr_rd8;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (wr_i && hit8) ##1 (rd_i && hit8) |=> (rdata_o == $past(wdata_i, 2));
  endproperty
  a_wr_rd8: assert property (p_wr_rd8) else $error("readback8 mismatch");

  property p_unmapped;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (rd_i && !hit7 && !hit8) |=> (rdata_o == lvs_pkg::READ_UNMAPPED);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");

  property p_isolate;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (wr_i && hit7) |=> $stable(regulator8_bank_a_setting);
  endproperty
  a_isolate: assert property (p_isolate) else $error("write leaked");

  // ---------------------------------------------------------------
  // Further checks on codes, read back and isolation
  // ---------------------------------------------------------------
  // Raw code of the first regulator follows the write
  property p_code7_raw;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (wr_i && hit7) |=> ##1
        (reg7_voltage_code_bank_a_o == $past(wdata_i[lvs_pkg::CODE_MSB:0], 2));
  endproperty
  a_code7_raw: assert property (p_code7_raw) else $error("code7 wrong");

  // Second regulator saturates above the top code
  property p_code8_sat;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (wr_i && hit8 && wdata_i[lvs_pkg::CODE_MSB:0] > lvs_pkg::CODE_MAX) |=> ##1
        (reg8_voltage_step_o == lvs_pkg::CODE_MAX - lvs_pkg::CODE_FLOOR);
  endproperty
  a_code8_sat: assert property (p_code8_sat) else $error("code8 not saturated");

  // Second regulator sits at the lowest voltage for the floor codes
  property p_floor8;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (wr_i && hit8 && wdata_i[lvs_pkg::CODE_MSB:0] <= lvs_pkg::CODE_FLOOR) |=> ##1
        (reg8_voltage_step_o == '0);
  endproperty
  a_floor8: assert property (p_floor8) else $error("code8 floor wrong");

  // Read of the second register returns its content
  property p_read8;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (rd_i && hit8) |=> (rdata_o == $past(regulator8_bank_a_setting));
  endproperty
  a_read8: assert property (p_read8) else $error("read8 mismatch");

  // Write then read of the first register returns the written byte
  property p_wr_rd7;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (wr_i && hit7) ##1 (rd_i && hit7) |=> (rdata_o == $past(wdata_i, 2));
  endproperty
  a_wr_rd7: assert property (p_wr_rd7) else $error("readback7 mismatch");

  // Write to the second register leaves the first alone
  property p_isolate8;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (wr_i && hit8) |=> $stable(regulator7_bank_a_setting);
  endproperty
  a_isolate8: assert property (p_isolate8) else $error("write leaked");

  // Writes to other addresses change neither register
  property p_unmapped_wr;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (wr_i && !hit7 && !hit8) |=>
        ($stable(regulator7_bank_a_setting) && $stable(regulator8_bank_a_setting));
  endproperty
  a_unmapped_wr: assert property (p_unmapped_wr) else $error("unmapped write landed");

  // First register only changes on its own write
  property p_hold7;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      !(wr_i && hit7) |=> $stable(regulator7_bank_a_setting);
  endproperty
  a_hold7: assert property (p_hold7) else $error("reg7 changed");

  // Read data stand until the next read
  property p_rdata_hold;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      !rd_i |=> $stable(rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule

// ### tb_ldo_voltage_setting_regs.sv
`timescale 1ns/100ps
module tb_ldo_voltage_setting_regs;
  logic       clk_sys_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic [7:0] addr_i    = 8'h00;
  logic [7:0] wdata_i   = 8'h00;
  logic       wr_i      = 1'b0;
  logic       rd_i      = 1'b0;
  logic       rd_seen   = 1'b0;
  logic [7:0] rdata_o;
  logic       sl7;
  logic       sl8;
  logic [5:0] code7;
  logic [5:0] code8;
  logic [5:0] step7;
  logic [5:0] step8;
  logic [7:0] model [2];
  logic [7:0] exp_q [$];
  logic [5:0] codes [8] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h37, 6'h38, 6'h39, 6'h3f};
  int         errors    = 0;
  int         tests_run = 0;
  int         seed      = 32'h440bff3e;

  // Clock, 8 ns period
  always #4 clk_sys_i = ~clk_sys_i;

  lvs_top dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .reg7_sleep_select_bank_a_o(sl7), .reg7_voltage_code_bank_a_o(code7),
    .reg7_voltage_step_o(step7), .reg8_sleep_select_bank_a_o(sl8),
    .reg8_voltage_code_bank_a_o(code8), .reg8_voltage_step_o(step8));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Saturating step: 0 up to code 2, 0x36 from code 0x38
  function automatic logic [7:0] step_of(input logic [7:0] c);
    c = {2'b00, c[5:0]};
    return (c <= 8'h02) ? 8'h00 : (c >= 8'h38) ? 8'h36 : c - 8'h02;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_i    <= 1'b1;
    rd_i    <= 1'b0;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    if (a == lvs_pkg::REG7_A_OFFSET) model[0] = d;
    if (a == lvs_pkg::REG8_A_OFFSET) model[1] = d;
  endtask

  task automatic rd(input logic [7:0] a);
    rd_i   <= 1'b1;
    wr_i   <= 1'b0;
    addr_i <= a;
    exp_q.push_back(a == lvs_pkg::REG7_A_OFFSET ? model[0] :
                    a == lvs_pkg::REG8_A_OFFSET ? model[1] : lvs_pkg::READ_UNMAPPED);
    @(posedge clk_sys_i);
  endtask

  task automatic chk_fields;
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    check({7'h00, sl7}, {7'h00, model[0][7]}, "sleep7");
    check({7'h00, sl8}, {7'h00, model[1][7]}, "sleep8");
    check({2'b00, code7}, {2'b00, model[0][5:0]}, "code7");
    check({2'b00, step7}, step_of(model[0]), "step7");
    check({2'b00, code8}, {2'b00, model[1][5:0]}, "code8");
    check({2'b00, step8}, step_of(model[1]), "step8");
    @(posedge clk_sys_i);
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Read monitor, compares with the oldest note
  always @(posedge clk_sys_i)
  begin
    if (rd_seen) check(rdata_o, exp_q.pop_front(), "rdata");
    rd_seen <= rd_i;
  end

  // Main sequence
  initial
  begin
    model = '{lvs_pkg::REG_RESET, lvs_pkg::REG_RESET};
    repeat (20) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rd(lvs_pkg::REG7_A_OFFSET);
    rd(lvs_pkg::REG8_A_OFFSET);
    chk_fields();
    $display("test reset values done");
    for (int i = 0; i < 8; i++)
    begin
      wr(lvs_pkg::REG7_A_OFFSET, {i[0], i[1], codes[i]});
      rd(lvs_pkg::REG7_A_OFFSET);
      wr(lvs_pkg::REG8_A_OFFSET, {~i[0], i[2], codes[7 - i]});
      chk_fields();
      rd(lvs_pkg::REG8_A_OFFSET);
    end
    $display("test code boundaries done");
    repeat (20)
    begin
      wr(lvs_pkg::REG7_A_OFFSET, 8'($random(seed)));
      rd(lvs_pkg::REG7_A_OFFSET);
      wr(lvs_pkg::REG8_A_OFFSET, 8'($random(seed)));
      rd(lvs_pkg::REG8_A_OFFSET);
      chk_fields();
    end
    $display("test random values done");
    wr(8'hae, 8'hff);
    rd(8'hae);
    wr(8'hb1, 8'h55);
    rd(8'hb1);
    rd(lvs_pkg::REG7_A_OFFSET);
    rd(lvs_pkg::REG8_A_OFFSET);
    chk_fields();
    $display("test unmapped access done");
    repeat (3) @(posedge clk_sys_i);
    report_and_stop();
  end

  // Watchdog
  initial
  begin
    #200000;
    errors++;
    report_and_stop();
  end
endmodule
